// [arp_pkg.sv]
// Shared constants and carrier types for the auto-restart protection sequencer
package arp_pkg;

    // Clock rate and derived timing
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned BLANK_TIME_MS = 20;
    localparam int unsigned SPIKE_TIME_US = 30;
    localparam int unsigned OVP_TIME_US   = 120;
    localparam int unsigned EXT_TIME_MS   = 1;
    localparam int unsigned BLANK_CYCLES  = BLANK_TIME_MS * (1_000_000 / CLK_PERIOD_NS);
    localparam int unsigned SPIKE_CYCLES  = SPIKE_TIME_US * (1_000 / CLK_PERIOD_NS);
    localparam int unsigned OVP_CYCLES    = OVP_TIME_US * (1_000 / CLK_PERIOD_NS);
    localparam int unsigned EXT_CYCLES    = EXT_TIME_MS * (1_000_000 / CLK_PERIOD_NS);
    localparam int unsigned CNT_W         = 22;

    // Comparator and sensor flags from the analog front end
    typedef struct packed {
        logic fb_overload;    // Feedback above overload level
        logic extend_high;    // Blanking-extend node above upper level
        logic extend_low;     // Blanking-extend node below external-enable level
        logic ovp_soft;       // Supply above soft-start overvoltage level
        logic ovp_hard;       // Supply above hard overvoltage level
        logic over_temp;      // Junction above shutdown temperature
        logic supply_uv;      // Supply below turn-off threshold
        logic fb_low;         // Feedback held low
        logic soft_start;     // Soft-start phase active
        logic burst_active;   // Burst mode active
    } sense_s;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_RUN,
        ST_RESTART
    } prot_state_e;

endpackage

// [auto_restart_protection_control.sv]
// Protection sequencer: blanking timers, restart decision and gate-drive enable

`timescale 1ns/1ps
`default_nettype none

module auto_restart_protection_control
    import arp_pkg::*;
(
    input  wire logic   clk,              // 100 MHz oscillator clock
    input  wire logic   rst_n,            // Synchronous reset, active low
    input  wire sense_s sense_in,         // Raw comparator and sensor flags
    output logic        gate_enable,      // Gate drive switching allowed
    output logic        blank_clamp_switch, // High while clamp holds extend node
    output logic        startup_cell_on,  // Startup cell enabled
    output logic        restart_active    // In auto-restart mode
);

    // Two-stage synchroniser; first stage is read only by the second
    sense_s sync1_r, sync1_nxt, sync2_r, sync2_nxt;
    always_comb begin
        sync1_nxt = sense_in;
        sync2_nxt = sync1_r;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
        end
    end

    // Timers and state
    prot_state_e      state_r, state_nxt;
    logic [CNT_W-1:0] blank_cnt_r, blank_cnt_nxt;
    logic [CNT_W-1:0] spike_cnt_r, spike_cnt_nxt;
    logic [CNT_W-1:0] ovp_cnt_r, ovp_cnt_nxt;
    logic [CNT_W-1:0] ext_cnt_r, ext_cnt_nxt;
    logic             blank_done_r, blank_done_nxt;
    logic             gate_r, gate_nxt;
    logic             clamp_r, clamp_nxt;
    logic             restart_r, restart_nxt;
    logic             fault_now;
    logic             and_gate;
    logic             ext_req;
    logic             ovp_hard_ok;

    localparam logic [CNT_W-1:0] BLANK_LAST = CNT_W'(BLANK_CYCLES - 1);
    localparam logic [CNT_W-1:0] SPIKE_LAST = CNT_W'(SPIKE_CYCLES - 1);
    localparam logic [CNT_W-1:0] OVP_LAST   = CNT_W'(OVP_CYCLES - 1);
    localparam logic [CNT_W-1:0] EXT_LAST   = CNT_W'(EXT_CYCLES - 1);

    // Immediate fault terms and the restart gate
    always_comb begin
        ovp_hard_ok = sync2_r.ovp_hard && !sync2_r.burst_active;
        and_gate    = blank_done_r && sync2_r.extend_high;
        // Blanking after startup keeps a slowly settling node from tripping
        ext_req     = sync2_r.extend_low && (ext_cnt_r == EXT_LAST);
        fault_now   = (sync2_r.soft_start && sync2_r.ovp_soft && sync2_r.fb_overload)
                    || (ovp_cnt_r == OVP_LAST)
                    || sync2_r.over_temp
                    || sync2_r.supply_uv
                    || (and_gate && spike_cnt_r == SPIKE_LAST);
    end

    // Next-state logic for timers, clamp and gate drive
    always_comb begin
        state_nxt      = state_r;
        blank_cnt_nxt  = blank_cnt_r;
        spike_cnt_nxt  = '0;
        blank_done_nxt = blank_done_r;
        clamp_nxt      = clamp_r;
        restart_nxt    = restart_r;
        ovp_cnt_nxt    = ovp_hard_ok ? ((ovp_cnt_r == OVP_LAST) ? ovp_cnt_r
                                         : ovp_cnt_r + 1'b1) : '0;
        ext_cnt_nxt    = (ext_cnt_r == EXT_LAST) ? ext_cnt_r : ext_cnt_r + 1'b1;
        gate_nxt       = gate_r;
        case (state_r)
            ST_RUN: begin
                if (sync2_r.fb_overload) begin
                    if (!blank_done_r) begin
                        blank_cnt_nxt = blank_cnt_r + 1'b1;
                        if (blank_cnt_r == BLANK_LAST) begin
                            blank_done_nxt = 1'b1;
                            clamp_nxt      = 1'b0;
                        end
                    end
                    if (and_gate) begin
                        spike_cnt_nxt = (spike_cnt_r == SPIKE_LAST) ? spike_cnt_r
                                        : spike_cnt_r + 1'b1;
                    end
                end else begin
                    blank_cnt_nxt  = '0;
                    blank_done_nxt = 1'b0;
                    clamp_nxt      = 1'b1;
                end
                // Low feedback or external request blocks switching at once
                gate_nxt = !sync2_r.fb_low && !ext_req;
                if (fault_now || ext_req) begin
                    state_nxt   = ST_RESTART;
                    restart_nxt = 1'b1;
                    gate_nxt    = 1'b0;
                end
            end
            ST_RESTART: begin
                // Supply decays off-chip; reset by undervoltage re-runs startup
                gate_nxt       = 1'b0;
                blank_cnt_nxt  = '0;
                blank_done_nxt = 1'b0;
                clamp_nxt      = 1'b1;
                if (sync2_r.soft_start && !fault_now && !ext_req) begin
                    state_nxt   = ST_RUN;
                    restart_nxt = 1'b0;
                end
            end
            default: begin
                state_nxt   = ST_RESTART;
                restart_nxt = 1'b1;
                gate_nxt    = 1'b0;
            end
        endcase
    end

    // State and timer registers; a synchronous reset keeps every path on the one clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r      <= ST_RUN;
            blank_cnt_r  <= '0;
            spike_cnt_r  <= '0;
            ovp_cnt_r    <= '0;
            ext_cnt_r    <= '0;
            blank_done_r <= 1'b0;
            gate_r       <= 1'b0;
            clamp_r      <= 1'b1;
            restart_r    <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            blank_cnt_r  <= blank_cnt_nxt;
            spike_cnt_r  <= spike_cnt_nxt;
            ovp_cnt_r    <= ovp_cnt_nxt;
            ext_cnt_r    <= ext_cnt_nxt;
            blank_done_r <= blank_done_nxt;
            gate_r       <= gate_nxt;
            clamp_r      <= clamp_nxt;
            restart_r    <= restart_nxt;
        end
    end

    // Outputs straight from flops
    assign gate_enable        = gate_r;
    assign blank_clamp_switch = clamp_r;
    assign restart_active     = restart_r;
    assign startup_cell_on    = restart_r;

    // Checks
    a_clamp_opens_blank: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == ST_RUN && sync2_r.fb_overload && !blank_done_r && blank_cnt_r == BLANK_LAST)
        |=> !blank_clamp_switch)
        else $error("clamp did not open at end of blanking");
    a_overload_clears: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == ST_RUN && !sync2_r.fb_overload) |=> blank_clamp_switch && blank_cnt_r == 0)
        else $error("blanking not cleared after overload went away");
    a_spike_then_restart: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == ST_RUN && and_gate && spike_cnt_r == SPIKE_LAST) |=> restart_active)
        else $error("no restart after spike blanking");
    a_no_early_restart: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(restart_active) |-> $past(fault_now || ext_req))
        else $error("restart without a cause");
    a_ovp_hard_time: assert property (@(posedge clk) disable iff (!rst_n)
        (ovp_cnt_r == OVP_LAST && state_r == ST_RUN) |=> restart_active)
        else $error("hard overvoltage did not restart");
    a_burst_masks_ovp: assert property (@(posedge clk) disable iff (!rst_n)
        sync2_r.burst_active |=> ovp_cnt_r == 0)
        else $error("overvoltage counted during burst");
    a_temp_restart: assert property (@(posedge clk) disable iff (!rst_n)
        (sync2_r.over_temp && state_r == ST_RUN) |=> restart_active && !gate_enable)
        else $error("overtemperature did not restart");
    a_fb_low_nogate: assert property (@(posedge clk) disable iff (!rst_n)
        sync2_r.fb_low |=> !gate_enable)
        else $error("gate active with feedback low");
    a_ext_blanked: assert property (@(posedge clk) disable iff (!rst_n)
        (ext_cnt_r != EXT_LAST && state_r == ST_RUN && !fault_now) |=> !restart_active)
        else $error("external request not blanked at startup");
    a_uv_startup: assert property (@(posedge clk) disable iff (!rst_n)
        (sync2_r.supply_uv) |=> startup_cell_on)
        else $error("undervoltage did not enable startup cell");
    a_ext_stops_gate: assert property (@(posedge clk) disable iff (!rst_n)
        (ext_req && state_r == ST_RUN) |=> !gate_enable && restart_active)
        else $error("external request did not stop gate drive");
    a_resume_clean: assert property (@(posedge clk) disable iff (!rst_n)
        (state_r == ST_RESTART && sync2_r.soft_start && !fault_now && !ext_req)
        |=> !restart_active && !startup_cell_on)
        else $error("no return to run after clean re-check");

    c_overload_restart: cover property (@(posedge clk) disable iff (!rst_n)
        and_gate && spike_cnt_r == SPIKE_LAST);
    c_ext_restart: cover property (@(posedge clk) disable iff (!rst_n)
        ext_req && state_r == ST_RUN);
    c_resume: cover property (@(posedge clk) disable iff (!rst_n)
        state_r == ST_RESTART && state_nxt == ST_RUN);
    c_ovp_hard: cover property (@(posedge clk) disable iff (!rst_n) ovp_cnt_r == OVP_LAST);

endmodule

`default_nettype wire

// [auto_restart_protection_control_tb.sv]
// Self-checking bench for the auto-restart protection sequencer
`timescale 1ns/1ps
`default_nettype none

module auto_restart_protection_control_tb
    import arp_pkg::*;
;
    localparam int TIMEOUT = 102000; // Run ends near 100050 cycles, after the 1 ms blanking

    logic   clk;
    logic   rst_n;
    sense_s sense;
    logic   gate_enable;
    logic   blank_clamp_switch;
    logic   startup_cell_on;
    logic   restart_active;
    int     num_errors  = 0;
    int     comparisons = 0;
    int     cycles      = 0;

    auto_restart_protection_control i_auto_restart_protection_control (
        .clk                (clk),
        .rst_n              (rst_n),
        .sense_in           (sense),
        .gate_enable        (gate_enable),
        .blank_clamp_switch (blank_clamp_switch),
        .startup_cell_on    (startup_cell_on),
        .restart_active     (restart_active)
    );

    // Free-running 100 MHz clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic give_verdict();
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Hang guard: a run past the ceiling counts as a mismatch
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT) begin
            num_errors++;
            $display("[FAIL] %0t timeout", $time);
            give_verdict();
        end
    end

    task automatic chk(logic got, logic exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %b expected %b", $time, got, exp);
        end
    endtask

    // Outputs are sampled on the falling edge, well clear of register updates
    task automatic tick(int k);
        repeat (k) @(negedge clk);
    endtask

    task automatic drive(sense_s v);
        @(posedge clk);
        sense <= v;
    endtask

    task automatic wait_restart(int lim, output int cnt);
        cnt = 0;
        while (restart_active !== 1'b1 && cnt < lim) begin
            @(negedge clk);
            cnt++;
        end
    endtask

    // Clear the fault, then let soft start run so the re-check can release it
    task automatic recover();
        sense_s v;
        int     k;
        v = '0;
        v.soft_start = 1'b1;
        drive(v);
        k = 0;
        while (restart_active !== 1'b0 && k < 20) begin
            @(negedge clk);
            k++;
        end
        chk(restart_active, 1'b0);
        drive('0);
        tick(5);
        chk(gate_enable, 1'b1);
    endtask

    // A fault that must act at once, with no blanking delay
    task automatic immediate(sense_s v);
        int cnt;
        drive(v);
        wait_restart(4, cnt);
        chk(restart_active, 1'b1);
        chk(gate_enable, 1'b0);
        chk(startup_cell_on, 1'b1);
    endtask

    // Reset held for eight edges; reset values are checked before release
    task automatic test_reset();
        rst_n <= 1'b0;
        sense <= '0;
        repeat (7) @(posedge clk);
        tick(1);
        chk(gate_enable, 1'b0);
        chk(blank_clamp_switch, 1'b1);
        chk(restart_active, 1'b0);
        chk(startup_cell_on, 1'b0);
        @(posedge clk);
        rst_n <= 1'b1;
    endtask

    // External request in the first millisecond is blanked
    task automatic test_ext_blanked();
        sense_s v;
        v = '0;
        v.extend_low = 1'b1;
        drive(v);
        tick(50);
        chk(restart_active, 1'b0);
        chk(gate_enable, 1'b1);
        drive('0);
    endtask

    // Overtemperature, then a re-check while the fault persists
    task automatic test_over_temp();
        sense_s v;
        v = '0;
        v.over_temp = 1'b1;
        immediate(v);
        v.soft_start = 1'b1;
        drive(v);
        tick(10);
        chk(restart_active, 1'b1);
        recover();
    endtask

    // Undervoltage restarts at once with the startup cell on
    task automatic test_undervoltage();
        sense_s v;
        v = '0;
        v.supply_uv = 1'b1;
        immediate(v);
        recover();
    endtask

    // Soft-start overvoltage is a fault only with overload inside soft start
    task automatic test_soft_ovp();
        sense_s v;
        v = '0;
        v.ovp_soft = 1'b1;
        v.fb_overload = 1'b1;
        v.soft_start = 1'b1;
        immediate(v);
        recover();
        v.fb_overload = 1'b0;
        drive(v);
        tick(20);
        chk(restart_active, 1'b0);
        v.fb_overload = 1'b1;
        v.soft_start = 1'b0;
        drive(v);
        tick(20);
        chk(restart_active, 1'b0);
        drive('0);
    endtask

    // Short overload stays behind the blanking counter
    task automatic test_short_overload();
        sense_s v;
        v = '0;
        v.fb_overload = 1'b1;
        drive(v);
        tick(50);
        chk(blank_clamp_switch, 1'b1);
        chk(restart_active, 1'b0);
        chk(gate_enable, 1'b1);
        drive('0);
        tick(5);
        chk(blank_clamp_switch, 1'b1);
    endtask

    // Feedback held low stops switching without restart
    task automatic test_fb_low();
        sense_s v;
        v = '0;
        v.fb_low = 1'b1;
        drive(v);
        tick(5);
        chk(gate_enable, 1'b0);
        chk(restart_active, 1'b0);
        drive('0);
        tick(5);
        chk(gate_enable, 1'b1);
    endtask

    // A broken overvoltage stretch starts the qualification time afresh
    task automatic test_ovp_interrupted();
        sense_s v;
        v = '0;
        v.ovp_hard = 1'b1;
        drive(v);
        tick(OVP_CYCLES - 200);
        drive('0);
        tick(5);
        drive(v);
        tick(OVP_CYCLES - 200);
        chk(restart_active, 1'b0);
        drive('0);
        tick(5);
    endtask

    // Hard overvoltage needs its full qualification time
    task automatic test_ovp_hard();
        sense_s v;
        int     n;
        v = '0;
        v.ovp_hard = 1'b1;
        drive(v);
        wait_restart(OVP_CYCLES + 100, n);
        chk(n >= OVP_CYCLES - 10 && n <= OVP_CYCLES + 10, 1'b1);
        chk(restart_active, 1'b1);
        recover();
    endtask

    // Hard overvoltage is ignored in burst mode
    task automatic test_burst_mask();
        sense_s v;
        v = '0;
        v.ovp_hard = 1'b1;
        v.burst_active = 1'b1;
        drive(v);
        tick(OVP_CYCLES + 500);
        chk(restart_active, 1'b0);
        drive('0);
        tick(5);
    endtask

    // Past the startup blanking an external request stops switching and restarts
    task automatic test_ext_request();
        sense_s v;
        while (cycles < EXT_CYCLES + 20) @(negedge clk);
        v = '0;
        v.extend_low = 1'b1;
        drive(v);
        tick(4);
        chk(gate_enable, 1'b0);
        chk(restart_active, 1'b1);
        v.soft_start = 1'b1;
        drive(v);
        tick(10);
        chk(restart_active, 1'b1);
        recover();
    endtask

    // Scenario order; the external request waits out the 1 ms blanking, so it runs last
    initial begin
        test_reset();
        test_ext_blanked();
        test_over_temp();
        test_undervoltage();
        test_soft_ovp();
        test_short_overload();
        test_fb_low();
        test_ovp_interrupted();
        test_ovp_hard();
        test_burst_mask();
        test_ext_request();
        give_verdict();
    end
endmodule

`default_nettype wire
